/* hw/cpu_trap_interrupt_sequencer.sv */
// Design decisions made here: the AHB-Lite slave port and the address map.
`default_nettype none
module cpu_trap_interrupt_sequencer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic instr_valid,
  input wire logic [15:0] instr_opcode,
  input wire logic [15:0] instr_next_pc,
  output logic instr_ready,
  output logic txn_valid,
  output trap_seq_pkg::txn_s txn,
  input wire logic txn_done,
  input wire logic [15:0] txn_rdata,
  input wire logic halt_n,
  input wire logic power_fail_n,
  input wire logic [3:0] coded_priority_n,
  input wire logic external_vector_n,
  output logic bus_clear_n,
  output logic [7:0] processor_status_word
);
  trap_seq_pkg::seq_state_e state_r;
  trap_seq_pkg::sel_e sel_c;
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic halt_q_r;
  logic pf_q_r;
  logic halt_evt_r;
  logic pf_evt_r;
  logic [7:0] psw_r;
  logic [15:0] pc_r;
  logic [15:0] sp_r;
  logic [15:0] vec_r;
  logic [15:0] mode_r;
  logic [15:0] mode_load_r;
  logic [15:0] restart_r;
  logic itrap_r;
  logic [15:0] itrap_vec_r;
  logic trace_flag_r;
  logic in_pf_r;
  logic is_halt_r;
  logic [3:0] grp_r;
  logic [1:0] pos_r;
  logic bus_clear_n_r;
  logic wr_en_r;
  logic [7:0] waddr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_c;
  logic halt_s;
  logic pf_s;
  logic [3:0] cp_s;
  logic ext_vec_s;
  logic accept;
  logic itrap_c;
  logic [15:0] itrap_vec_c;
  logic cc_op;
  logic [2:0] cp_lvl;
  logic [15:0] cp_base;
  logic [15:0] cp_vec;
  logic cp_req;
  logic trace_pend;
  logic wake;
  logic [15:0] sel_vec;
  logic ahb_acc;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // full decode of the defined instruction space, octal digit by digit
  function automatic logic is_defined(input logic [15:0] op);
    logic [2:0] a;
    logic [2:0] b;
    logic [2:0] c;
    logic ok;
    a = op[14:12];
    b = op[11:9];
    c = op[8:6];
    ok = 1'b0;
    if (a != 3'd0 && a != 3'd7) begin
      ok = 1'b1;
    end else if (a == 3'd7) begin
      ok = !op[15] && (b == 3'd4 || b == 3'd7);
    end else if (b == 3'd0 && !op[15]) begin
      case (c)
        3'd0: ok = op[5:3] == 3'd0;
        3'd2: ok = op[5:3] == 3'd0 || op[5];
        default: ok = 1'b1;
      endcase
    end else if (b <= 3'd5) begin
      ok = 1'b1;
    end else if (b == 3'd6) begin
      ok = c <= 3'd3 || c == 3'd7 || (op[15] && c == 3'd4);
    end
    return ok;
  endfunction

  // pins cross in on two flops before anything looks at them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 7'h7F;
      sync2_r <= 7'h7F;
    end else begin
      sync1_r <= {external_vector_n, coded_priority_n, power_fail_n, halt_n};
      sync2_r <= sync1_r;
    end
  end

  assign halt_s = sync2_r[0];
  assign pf_s = sync2_r[1];
  assign cp_s = sync2_r[5:2];
  assign ext_vec_s = !sync2_r[6];
  assign accept = state_r == trap_seq_pkg::ST_IDLE && instr_valid;
  assign instr_ready = state_r == trap_seq_pkg::ST_IDLE;
  assign cc_op = (instr_opcode & trap_seq_pkg::CC_OP_MASK) == trap_seq_pkg::CC_OP_BASE;
  assign trace_pend = trace_flag_r && !itrap_r;
  assign wake = halt_evt_r || pf_evt_r || cp_req;

  // halt and power-fail are edge events; set wins over the take
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_q_r <= 1'b1;
      pf_q_r <= 1'b1;
      halt_evt_r <= 1'b0;
      pf_evt_r <= 1'b0;
    end else begin
      halt_q_r <= halt_s;
      pf_q_r <= pf_s;
      halt_evt_r <= (halt_q_r && !halt_s) || (accept && instr_opcode == trap_seq_pkg::OP_HALT)
        || (halt_evt_r && sel_c != trap_seq_pkg::SEL_HALT);
      pf_evt_r <= (pf_q_r && !pf_s) || (pf_evt_r && sel_c != trap_seq_pkg::SEL_PF);
    end
  end

  always_comb begin
    case (cp_s[3:2])
      2'd0: begin
        cp_lvl = 3'd7;
        cp_base = trap_seq_pkg::CP7_BASE;
      end
      2'd1: begin
        cp_lvl = 3'd6;
        cp_base = trap_seq_pkg::CP6_BASE;
      end
      2'd2: begin
        cp_lvl = 3'd5;
        cp_base = trap_seq_pkg::CP5_BASE;
      end
      default: begin
        cp_lvl = 3'd4;
        cp_base = trap_seq_pkg::CP4_BASE;
      end
    endcase
    cp_vec = cp_base + {12'h000, cp_s[1:0], 2'b00};
    // relies on the requester holding the lines until acknowledged
    cp_req = cp_s != trap_seq_pkg::CP_IDLE && cp_lvl > psw_r[7:5];
  end

  // a trace that meets an instruction trap yields to it and is dropped when the trap is taken
  always_comb begin
    sel_c = trap_seq_pkg::SEL_NONE;
    sel_vec = trap_seq_pkg::VEC_TRACE;
    if (state_r == trap_seq_pkg::ST_ARB) begin
      if (halt_evt_r) begin
        sel_c = trap_seq_pkg::SEL_HALT;
      end else if (trace_pend) begin
        sel_c = trap_seq_pkg::SEL_TRACE;
      end else if (pf_evt_r) begin
        sel_c = trap_seq_pkg::SEL_PF;
        sel_vec = trap_seq_pkg::VEC_PF;
      end else if (cp_req) begin
        sel_c = trap_seq_pkg::SEL_CP;
        sel_vec = cp_vec;
      end else if (itrap_r) begin
        sel_c = trap_seq_pkg::SEL_ITRAP;
        sel_vec = itrap_vec_r;
      end
    end
  end

  always_comb begin
    itrap_c = 1'b1;
    itrap_vec_c = trap_seq_pkg::VEC_RSV;
    if (!is_defined(instr_opcode)) begin
      itrap_vec_c = trap_seq_pkg::VEC_RSV;
    end else if (instr_opcode == trap_seq_pkg::OP_IOT) begin
      itrap_vec_c = trap_seq_pkg::VEC_IOT;
    end else if (instr_opcode == trap_seq_pkg::OP_BPT) begin
      itrap_vec_c = trap_seq_pkg::VEC_TRACE;
    end else if (instr_opcode[15:9] == 7'h44) begin
      itrap_vec_c = instr_opcode[8] ? trap_seq_pkg::VEC_TRAP : trap_seq_pkg::VEC_EMT;
    end else if ((instr_opcode[15:6] == 10'h001 || instr_opcode[15:9] == 7'h04)
        && instr_opcode[5:3] == 3'd0) begin
      itrap_vec_c = trap_seq_pkg::VEC_ILLEGAL;
    end else if (instr_opcode == trap_seq_pkg::OP_RTI && in_pf_r) begin
      itrap_vec_c = trap_seq_pkg::VEC_RSV;
    end else begin
      itrap_c = 1'b0;
    end
  end

  always_comb begin
    txn_valid = 1'b1;
    txn.kind = trap_seq_pkg::TX_NOP;
    txn.addr = trap_seq_pkg::WORD_RST;
    txn.wdata = trap_seq_pkg::WORD_RST;
    case (state_r)
      trap_seq_pkg::ST_ACK: txn.kind = trap_seq_pkg::TX_INTERRUPT_ACKNOWLEDGE_CYCLE;
      trap_seq_pkg::ST_VREAD: begin
        txn.kind = trap_seq_pkg::TX_READ;
        txn.addr = vec_r;
      end
      trap_seq_pkg::ST_PUSH_PS: begin
        txn.kind = trap_seq_pkg::TX_WRITE;
        txn.addr = sp_r - trap_seq_pkg::STACK_STEP;
        txn.wdata = {8'h00, psw_r};
      end
      trap_seq_pkg::ST_PUSH_PC: begin
        txn.kind = trap_seq_pkg::TX_WRITE;
        txn.addr = sp_r - trap_seq_pkg::STACK_STEP;
        txn.wdata = pc_r;
      end
      trap_seq_pkg::ST_RD_PC: begin
        txn.kind = trap_seq_pkg::TX_READ;
        txn.addr = vec_r;
      end
      trap_seq_pkg::ST_RD_PS: begin
        txn.kind = trap_seq_pkg::TX_READ;
        txn.addr = vec_r + trap_seq_pkg::STACK_STEP;
      end
      trap_seq_pkg::ST_POP_PC, trap_seq_pkg::ST_POP_PS: begin
        txn.kind = trap_seq_pkg::TX_READ;
        txn.addr = sp_r;
      end
      trap_seq_pkg::ST_WREF: txn.kind = trap_seq_pkg::TX_REFRESH;
      trap_seq_pkg::ST_WPOLL, trap_seq_pkg::ST_RPOLL: txn.kind = trap_seq_pkg::TX_POLL;
      trap_seq_pkg::ST_WNOP, trap_seq_pkg::ST_RNOP: txn.kind = trap_seq_pkg::TX_NOP;
      default: txn_valid = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= trap_seq_pkg::ST_IDLE;
      psw_r <= trap_seq_pkg::PSW_RST;
      pc_r <= trap_seq_pkg::WORD_RST;
      sp_r <= trap_seq_pkg::WORD_RST;
      vec_r <= trap_seq_pkg::WORD_RST;
      itrap_r <= 1'b0;
      itrap_vec_r <= trap_seq_pkg::WORD_RST;
      trace_flag_r <= 1'b0;
      in_pf_r <= 1'b0;
      is_halt_r <= 1'b0;
      grp_r <= 4'h0;
      pos_r <= 2'h0;
      bus_clear_n_r <= 1'b1;
    end else begin
      if (wr_en_r) begin
        case (waddr_r)
          // software cannot touch the trace bit
          trap_seq_pkg::REG_PSW_OFS: psw_r <= (hwdata[7:0] & ~trap_seq_pkg::PSW_T_MASK)
            | (psw_r & trap_seq_pkg::PSW_T_MASK);
          trap_seq_pkg::REG_PC_OFS: pc_r <= hwdata[15:0];
          trap_seq_pkg::REG_SP_OFS: sp_r <= hwdata[15:0];
          default: ;
        endcase
      end
      case (state_r)
        trap_seq_pkg::ST_IDLE: if (instr_valid) begin
          pc_r <= instr_next_pc;
          trace_flag_r <= |(psw_r & trap_seq_pkg::PSW_T_MASK)
            && instr_opcode != trap_seq_pkg::OP_RTT;
          state_r <= trap_seq_pkg::ST_ARB;
          if (itrap_c) begin
            itrap_r <= 1'b1;
            itrap_vec_r <= itrap_vec_c;
          end
          if (cc_op) begin
            psw_r[3:0] <= instr_opcode[4] ? psw_r[3:0] | instr_opcode[3:0]
              : psw_r[3:0] & ~instr_opcode[3:0];
          end
          if (instr_opcode == trap_seq_pkg::OP_WAIT) begin
            state_r <= trap_seq_pkg::ST_WREF;
          end
          if (instr_opcode == trap_seq_pkg::OP_RESET) begin
            state_r <= trap_seq_pkg::ST_RNOP;
            bus_clear_n_r <= 1'b0;
            grp_r <= 4'h0;
            pos_r <= 2'h0;
          end
          if (instr_opcode == trap_seq_pkg::OP_RTT
              || (instr_opcode == trap_seq_pkg::OP_RTI && !in_pf_r)) begin
            state_r <= trap_seq_pkg::ST_POP_PC;
          end
          if (instr_opcode == trap_seq_pkg::OP_RTI) begin
            in_pf_r <= 1'b0;
          end
        end
        trap_seq_pkg::ST_ARB: begin
          vec_r <= sel_vec;
          is_halt_r <= sel_c == trap_seq_pkg::SEL_HALT;
          if (sel_c != trap_seq_pkg::SEL_NONE) begin
            trace_flag_r <= 1'b0;
          end
          if (sel_c == trap_seq_pkg::SEL_ITRAP) begin
            itrap_r <= 1'b0;
          end
          if (sel_c == trap_seq_pkg::SEL_PF) begin
            in_pf_r <= 1'b1;
          end
          case (sel_c)
            trap_seq_pkg::SEL_NONE: state_r <= trap_seq_pkg::ST_IDLE;
            trap_seq_pkg::SEL_PF, trap_seq_pkg::SEL_CP: state_r <= trap_seq_pkg::ST_ACK;
            default: state_r <= trap_seq_pkg::ST_PUSH_PS;
          endcase
        end
        trap_seq_pkg::ST_ACK: if (txn_done) begin
          // vector read after the ack only for an externally supplied vector
          state_r <= (ext_vec_s && vec_r != trap_seq_pkg::VEC_PF) ? trap_seq_pkg::ST_VREAD
            : trap_seq_pkg::ST_PUSH_PS;
        end
        trap_seq_pkg::ST_VREAD: if (txn_done) begin
          vec_r <= txn_rdata;
          state_r <= trap_seq_pkg::ST_PUSH_PS;
        end
        trap_seq_pkg::ST_PUSH_PS: if (txn_done) begin
          sp_r <= sp_r - trap_seq_pkg::STACK_STEP;
          state_r <= trap_seq_pkg::ST_PUSH_PC;
        end
        trap_seq_pkg::ST_PUSH_PC: if (txn_done) begin
          sp_r <= sp_r - trap_seq_pkg::STACK_STEP;
          state_r <= trap_seq_pkg::ST_RD_PC;
          if (is_halt_r) begin
            pc_r <= restart_r;
            psw_r <= trap_seq_pkg::HALT_PSW;
            state_r <= trap_seq_pkg::ST_ARB;
          end
        end
        trap_seq_pkg::ST_RD_PC: if (txn_done) begin
          pc_r <= txn_rdata;
          state_r <= trap_seq_pkg::ST_RD_PS;
        end
        trap_seq_pkg::ST_RD_PS: if (txn_done) begin
          psw_r <= txn_rdata[7:0] & ~trap_seq_pkg::PSW_T_MASK;
          state_r <= trap_seq_pkg::ST_ARB;
        end
        trap_seq_pkg::ST_POP_PC: if (txn_done) begin
          pc_r <= txn_rdata;
          sp_r <= sp_r + trap_seq_pkg::STACK_STEP;
          state_r <= trap_seq_pkg::ST_POP_PS;
        end
        trap_seq_pkg::ST_POP_PS: if (txn_done) begin
          psw_r <= txn_rdata[7:0];
          sp_r <= sp_r + trap_seq_pkg::STACK_STEP;
          state_r <= trap_seq_pkg::ST_ARB;
        end
        trap_seq_pkg::ST_WREF: if (txn_done) begin
          state_r <= trap_seq_pkg::ST_WNOP;
        end
        trap_seq_pkg::ST_WNOP: if (txn_done) begin
          state_r <= trap_seq_pkg::ST_WPOLL;
        end
        trap_seq_pkg::ST_WPOLL: if (txn_done) begin
          state_r <= wake ? trap_seq_pkg::ST_ARB : trap_seq_pkg::ST_WREF;
        end
        trap_seq_pkg::ST_RNOP: if (txn_done) begin
          pos_r <= pos_r + 2'h1;
          if (pos_r == trap_seq_pkg::RST_GROUP_LEN - 2'h1) begin
            pos_r <= 2'h0;
            grp_r <= grp_r + 4'h1;
            if (grp_r == trap_seq_pkg::RST_GROUPS - 4'h1) begin
              bus_clear_n_r <= 1'b1;
              state_r <= trap_seq_pkg::ST_RPOLL;
            end
          end
        end
        trap_seq_pkg::ST_RPOLL: if (txn_done) begin
          state_r <= trap_seq_pkg::ST_ARB;
        end
        default: state_r <= trap_seq_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= trap_seq_pkg::WORD_RST;
    end else if (accept && instr_opcode == trap_seq_pkg::OP_RESET) begin
      mode_r <= mode_load_r;
    end
  end

  assign bus_clear_n = bus_clear_n_r;
  assign processor_status_word = psw_r;

  // zero-wait slave: reads are sampled in the address phase
  assign ahb_acc = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_comb begin
    rd_c = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      case (haddr[7:0])
        trap_seq_pkg::REG_PSW_OFS: rd_c = {24'h00_0000, psw_r};
        trap_seq_pkg::REG_PC_OFS: rd_c = {16'h0000, pc_r};
        trap_seq_pkg::REG_SP_OFS: rd_c = {16'h0000, sp_r};
        trap_seq_pkg::REG_MODE_LOAD_OFS: rd_c = {16'h0000, mode_load_r};
        trap_seq_pkg::REG_MODE_OFS: rd_c = {16'h0000, mode_r};
        trap_seq_pkg::REG_STATUS_OFS: rd_c = {vec_r, 9'h000, bus_clear_n_r, in_pf_r,
          itrap_r, trace_flag_r, halt_evt_r, pf_evt_r, instr_ready};
        trap_seq_pkg::REG_RESTART_OFS: rd_c = {16'h0000, restart_r};
        default: rd_c = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_r <= 1'b0;
      waddr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_en_r <= ahb_acc && hwrite && haddr[31:8] == 24'h00_0000;
      waddr_r <= haddr[7:0];
      hrdata_r <= (ahb_acc && !hwrite) ? rd_c : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_load_r <= trap_seq_pkg::WORD_RST;
      restart_r <= trap_seq_pkg::WORD_RST;
    end else if (wr_en_r) begin
      if (waddr_r == trap_seq_pkg::REG_MODE_LOAD_OFS) begin
        mode_load_r <= hwdata[15:0];
      end
      if (waddr_r == trap_seq_pkg::REG_RESTART_OFS) begin
        restart_r <= hwdata[15:0];
      end
    end
  end

  a_iot_vector: assert property (
    accept && instr_opcode == trap_seq_pkg::OP_IOT |=> itrap_r
      && itrap_vec_r == trap_seq_pkg::VEC_IOT) else $error("io trap vector wrong");
  a_reserved_trap: assert property (
    accept && !is_defined(instr_opcode) |=> itrap_r
      && itrap_vec_r == trap_seq_pkg::VEC_RSV) else $error("reserved opcode not trapped");
  a_jump_reg: assert property (
    accept && instr_opcode[15:6] == 10'h001 && instr_opcode[5:3] == 3'd0
      |=> itrap_vec_r == trap_seq_pkg::VEC_ILLEGAL) else $error("register jump not trapped");
  a_halt_restart: assert property (
    state_r == trap_seq_pkg::ST_PUSH_PC && is_halt_r && txn_done
      |=> pc_r == $past(restart_r) && psw_r == trap_seq_pkg::HALT_PSW)
    else $error("halt restart state wrong");
  a_trace_vector: assert property (
    sel_c == trap_seq_pkg::SEL_TRACE |=> vec_r == trap_seq_pkg::VEC_TRACE
      ##1 state_r == trap_seq_pkg::ST_PUSH_PC || state_r == trap_seq_pkg::ST_PUSH_PS)
    else $error("trace entry wrong");
  a_t_bit_set: assert property (
    $rose(psw_r[4]) |-> $past(state_r) == trap_seq_pkg::ST_POP_PS)
    else $error("trace bit set outside return");
  a_pf_vector: assert property (
    sel_c == trap_seq_pkg::SEL_PF |=> vec_r == trap_seq_pkg::VEC_PF
      && state_r == trap_seq_pkg::ST_ACK) else $error("power-fail entry wrong");
  a_pf_return: assert property (
    accept && instr_opcode == trap_seq_pkg::OP_RTI && in_pf_r |=> itrap_r
      && state_r == trap_seq_pkg::ST_ARB) else $error("power-fail return not trapped");
  a_trace_fetch: assert property (
    accept && psw_r[4] && instr_opcode != trap_seq_pkg::OP_RTT |=> trace_flag_r)
    else $error("trace flag not latched");
  a_prio_order: assert property (
    sel_c == trap_seq_pkg::SEL_CP |-> !halt_evt_r && !pf_evt_r && !trace_pend)
    else $error("coded request beat higher event");
  a_wait_loop: assert property (
    state_r == trap_seq_pkg::ST_WPOLL && txn_done && !wake
      |=> state_r == trap_seq_pkg::ST_WREF) else $error("wait loop broken");
  a_reset_bus_clear_n: assert property (
    accept && instr_opcode == trap_seq_pkg::OP_RESET |=> !bus_clear_n
      throughout (state_r == trap_seq_pkg::ST_RNOP)[*3]) else $error("bus clear dropped");
  a_cc_all_set: assert property (
    accept && instr_opcode == 16'h00BF |=> psw_r[3:0] == 4'hF)
    else $error("flag set-all failed");

  c_trace_taken: cover property (sel_c == trap_seq_pkg::SEL_TRACE);
  c_pf_entry: cover property (state_r == trap_seq_pkg::ST_ACK && vec_r == trap_seq_pkg::VEC_PF);
  c_reset_done: cover property (state_r == trap_seq_pkg::ST_RPOLL && txn_done);
  c_wait_wake: cover property (state_r == trap_seq_pkg::ST_WPOLL && txn_done && wake);
endmodule
`default_nettype wire

/* hw/trap_seq_pkg.sv */
`default_nettype none
package trap_seq_pkg;
  localparam logic [7:0] REG_PSW_OFS = 8'h00;
  localparam logic [7:0] REG_PC_OFS = 8'h04;
  localparam logic [7:0] REG_SP_OFS = 8'h08;
  localparam logic [7:0] REG_MODE_LOAD_OFS = 8'h0C;
  localparam logic [7:0] REG_MODE_OFS = 8'h10;
  localparam logic [7:0] REG_STATUS_OFS = 8'h14;
  localparam logic [7:0] REG_RESTART_OFS = 8'h18;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] PSW_T_MASK = 8'h10;
  localparam logic [7:0] HALT_PSW = 8'hE0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] VEC_ILLEGAL = 16'h0004;
  localparam logic [15:0] VEC_RSV = 16'h0008;
  localparam logic [15:0] VEC_TRACE = 16'h000C;
  localparam logic [15:0] VEC_IOT = 16'h0010;
  localparam logic [15:0] VEC_PF = 16'h0014;
  localparam logic [15:0] VEC_EMT = 16'h0018;
  localparam logic [15:0] VEC_TRAP = 16'h001C;
  localparam logic [15:0] CP7_BASE = 16'h0060;
  localparam logic [15:0] CP6_BASE = 16'h0040;
  localparam logic [15:0] CP5_BASE = 16'h0050;
  localparam logic [15:0] CP4_BASE = 16'h0030;
  localparam logic [3:0] CP_IDLE = 4'hF;
  localparam logic [15:0] OP_HALT = 16'h0000;
  localparam logic [15:0] OP_WAIT = 16'h0001;
  localparam logic [15:0] OP_RTI = 16'h0002;
  localparam logic [15:0] OP_BPT = 16'h0003;
  localparam logic [15:0] OP_IOT = 16'h0004;
  localparam logic [15:0] OP_RESET = 16'h0005;
  localparam logic [15:0] OP_RTT = 16'h0006;
  localparam logic [15:0] CC_OP_BASE = 16'h00A0;
  localparam logic [15:0] CC_OP_MASK = 16'hFFE0;
  localparam logic [3:0] RST_GROUPS = 4'h9;
  localparam logic [1:0] RST_GROUP_LEN = 2'h3;
  typedef enum logic [2:0] {TX_READ, TX_WRITE, TX_INTERRUPT_ACKNOWLEDGE_CYCLE, TX_REFRESH, TX_NOP, TX_POLL} txn_kind_e;
  typedef struct packed {
    txn_kind_e kind;
    logic [15:0] addr;
    logic [15:0] wdata;
  } txn_s;
  typedef enum logic [3:0] {ST_IDLE, ST_ARB, ST_ACK, ST_VREAD, ST_PUSH_PS, ST_PUSH_PC,
    ST_RD_PC, ST_RD_PS, ST_POP_PC, ST_POP_PS, ST_WREF, ST_WNOP, ST_WPOLL, ST_RNOP,
    ST_RPOLL} seq_state_e;
  typedef enum logic [2:0] {SEL_NONE, SEL_HALT, SEL_TRACE, SEL_PF, SEL_CP, SEL_ITRAP} sel_e;
endpackage
`default_nettype wire

/* verification/trap_bus_partner.sv */
`default_nettype none
module trap_bus_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic txn_valid,
  input wire trap_seq_pkg::txn_s txn,
  output logic txn_done,
  output logic [15:0] txn_rdata,
  input wire logic [3:0] cp_want,
  output logic [3:0] coded_priority_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  logic [1:0] npoll;
  logic slow;
  // alternate prompt and slow answers; data scrambles on every cycle without an answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 2'h0;
      slow <= 1'b0;
      txn_done <= 1'b0;
      txn_rdata <= 16'hA5A5;
    end else if (txn_valid && !txn_done && cnt == (slow ? 2'h2 : 2'h0)) begin
      txn_done <= 1'b1;
      txn_rdata <= ~txn.addr;
      cnt <= 2'h0;
      slow <= !slow;
    end else begin
      txn_done <= 1'b0;
      txn_rdata <= ~txn_rdata;
      cnt <= (txn_valid && !txn_done) ? cnt + 2'h1 : 2'h0;
    end
  end
  // raise the wanted level after two polls, hold it until acknowledged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coded_priority_n <= 4'hF;
      npoll <= 2'h0;
    end else if (cp_want == 4'hF
        || (txn_valid && txn_done && txn.kind == trap_seq_pkg::TX_INTERRUPT_ACKNOWLEDGE_CYCLE)) begin
      coded_priority_n <= 4'hF;
      npoll <= 2'h0;
    end else if (npoll == 2'h2) begin
      coded_priority_n <= cp_want;
    end else if (txn_valid && txn_done && txn.kind == trap_seq_pkg::TX_POLL) begin
      npoll <= npoll + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* verification/cpu_trap_interrupt_sequencer_test.sv */
`default_nettype none
module cpu_trap_interrupt_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, iv = 0, hrdy, hresp, irdy, tv, td, bcn;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [15:0] op = 0, npc = 0, trd;
  logic [7:0] psw;
  trap_seq_pkg::txn_s txn;
  trap_seq_pkg::txn_s lq[$];
  int failures = 0, n_checks = 0, nclr = 0, nq = 0;
  logic hn = 1, pfn = 1;
  logic [3:0] cpw = 4'hF, cpn;
  logic [15:0] xop[3] = '{16'h0002, 16'h0041, 16'h0008};
  logic [15:0] xvec[3] = '{trap_seq_pkg::VEC_RSV, trap_seq_pkg::VEC_ILLEGAL,
    trap_seq_pkg::VEC_RSV};
  logic [15:0] fop[4] = '{16'h00BF, 16'h00A3, 16'h00A0, 16'h00AF};
  logic [3:0] fex[4] = '{4'hF, 4'hC, 4'hC, 4'h0};
  cpu_trap_interrupt_sequencer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .instr_valid(iv),
    .instr_opcode(op), .instr_next_pc(npc), .instr_ready(irdy), .txn_valid(tv), .txn(txn),
    .txn_done(td), .txn_rdata(trd), .halt_n(hn), .power_fail_n(pfn),
    .coded_priority_n(cpn), .external_vector_n(1'b1), .bus_clear_n(bcn),
    .processor_status_word(psw));
  trap_bus_partner far_end (.hclk(hclk), .hresetn(hresetn), .txn_valid(tv), .txn(txn),
    .txn_done(td), .txn_rdata(trd), .cp_want(cpw), .coded_priority_n(cpn));
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) if (tv && td) begin
    lq.push_back(txn);
    if (bcn === 1'b0) nclr++;
  end
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task hang(input int i);
    if (i >= 3000) begin
      failures++;
      close_out;
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
    i = 0;
    do begin @(posedge hclk); i++; end while (hrdy !== 1'b1 && i < 3000);
    htrans <= 2'h0; hsel <= 0; hwdata <= d;
    do begin @(posedge hclk); i++; end while (hrdy !== 1'b1 && i < 3000);
    q = hrdata;
    hang(i);
  endtask
  task exec(input logic [15:0] o, input logic [15:0] p);
    int i;
    lq.delete();
    nclr = 0;
    @(posedge hclk);
    iv <= 1; op <= o; npc <= p;
    i = 0;
    do begin @(posedge hclk); i++; end while (irdy !== 1'b1 && i < 3000);
    iv <= 0;
    do begin @(posedge hclk); i++; end while ((irdy !== 1'b1 || tv !== 1'b0) && i < 3000);
    hang(i);
  endtask
  // kind and address of one logged transaction
  task ctx(input int n, input logic [2:0] k, input logic [15:0] a);
    chk({13'h0, lq[n].kind}, {13'h0, k});
    chk(lq[n].addr, a);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    ahb(1, trap_seq_pkg::REG_SP_OFS, 32'h1000);
    ahb(1, trap_seq_pkg::REG_PSW_OFS, 32'h0015);
    ahb(0, trap_seq_pkg::REG_PSW_OFS, 0);
    chk(q[15:0], 16'h0005);
    exec(trap_seq_pkg::OP_IOT, 16'h0200);
    chk(lq.size(), 16'h4);
    ctx(0, trap_seq_pkg::TX_WRITE, 16'h0FFE);
    chk(lq[0].wdata, 16'h0005);
    ctx(1, trap_seq_pkg::TX_WRITE, 16'h0FFC);
    chk(lq[1].wdata, 16'h0200);
    ctx(2, trap_seq_pkg::TX_READ, trap_seq_pkg::VEC_IOT);
    ctx(3, trap_seq_pkg::TX_READ, 16'h0012);
    chk({8'h0, psw}, 16'h00ED);
    $display("io trap done");
    for (int k = 0; k < 4; k++) begin
      exec(fop[k], 16'h0202);
      chk({12'h0, psw[3:0]}, {12'h0, fex[k]});
    end
    $display("flag ops done");
    ahb(1, trap_seq_pkg::REG_SP_OFS, 32'h0F00);
    exec(trap_seq_pkg::OP_RTI, 16'h0204);
    ctx(0, trap_seq_pkg::TX_READ, 16'h0F00);
    ctx(1, trap_seq_pkg::TX_READ, 16'h0F02);
    chk({8'h0, psw}, 16'h00FD);
    ahb(0, trap_seq_pkg::REG_PC_OFS, 0);
    chk(q[15:0], 16'hF0FF);
    exec(trap_seq_pkg::CC_OP_BASE, 16'h0300);
    chk(lq.size(), 16'h4);
    chk(lq[0].wdata, 16'h00FD);
    ctx(2, trap_seq_pkg::TX_READ, trap_seq_pkg::VEC_TRACE);
    chk(lq[1].wdata, 16'h0300);
    $display("trace done");
    ahb(1, trap_seq_pkg::REG_MODE_LOAD_OFS, 32'h1234);
    exec(trap_seq_pkg::OP_RESET, 16'h0400);
    chk(lq.size(), 16'd28);
    chk(nclr, 16'd27);
    ctx(26, trap_seq_pkg::TX_NOP, trap_seq_pkg::WORD_RST);
    ctx(27, trap_seq_pkg::TX_POLL, trap_seq_pkg::WORD_RST);
    chk({15'h0, bcn}, 16'h1);
    ahb(0, trap_seq_pkg::REG_MODE_OFS, 0);
    chk(q[15:0], 16'h1234);
    $display("bus reset done");
    ahb(1, trap_seq_pkg::REG_RESTART_OFS, 32'h2000);
    hn <= 0;
    pfn <= 0;
    repeat (4) @(posedge hclk);
    exec(trap_seq_pkg::CC_OP_BASE, 16'h0600);
    hn <= 1;
    pfn <= 1;
    chk(lq.size(), 16'h7);
    chk(lq[1].wdata, 16'h0600);
    ctx(2, trap_seq_pkg::TX_INTERRUPT_ACKNOWLEDGE_CYCLE, trap_seq_pkg::WORD_RST);
    chk(lq[3].wdata, 16'h00E0);
    chk(lq[4].wdata, 16'h2000);
    ctx(5, trap_seq_pkg::TX_READ, 16'h0014);
    ctx(6, trap_seq_pkg::TX_READ, 16'h0016);
    $display("halt and power-fail done");
    for (int k = 0; k < 3; k++) begin
      exec(xop[k], 16'h0700);
      chk(lq.size(), 16'h4);
      ctx(2, trap_seq_pkg::TX_READ, xvec[k]);
    end
    $display("instruction traps done");
    ahb(1, trap_seq_pkg::REG_PSW_OFS, 32'h0000);
    cpw <= 4'h5;
    exec(trap_seq_pkg::OP_WAIT, 16'h0500);
    cpw <= 4'hF;
    nq = lq.size();
    ctx(2, trap_seq_pkg::TX_POLL, trap_seq_pkg::WORD_RST);
    ctx(3, trap_seq_pkg::TX_REFRESH, trap_seq_pkg::WORD_RST);
    ctx(nq - 5, trap_seq_pkg::TX_INTERRUPT_ACKNOWLEDGE_CYCLE, trap_seq_pkg::WORD_RST);
    chk(lq[nq - 3].wdata, 16'h0500);
    ctx(nq - 2, trap_seq_pkg::TX_READ, 16'h0044);
    $display("wait done");
    close_out;
  end
endmodule
`default_nettype wire
